// >>> dv/test_pll_band_select.sv
// Bench for the PLL band select block: register tasks, calibration run.
// Assumes the lock model stands in for the analog PLL.
`timescale 1ns/1ps
`default_nettype none
module test_pll_band_select;
  import pll_band_pkg::*;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       cfg_wr = 1'b0;
  logic       cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic [7:0] rv;
  logic       lock_detect;
  logic       pll_active;
  logic       pll_lock;
  pll_cfg_t   pll_cfg;
  vco_band_t  vco_ctl;
  int         num_errors = 0;
  int         comparisons = 0;
  int         t;
  logic [5:0] b;
  int         temps [5] = '{-35, -20, 0, 30, 70};
  logic [5:0] rbs [3] = '{6'd5, 6'd40, 6'd62};
  always #5 mclk = ~mclk;
  pll_band_select #(.DWELL(4)) dut (.mclk(mclk), .rst(rst),
    .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .lock_detect(lock_detect),
    .pll_cfg(pll_cfg), .vco_ctl(vco_ctl), .pll_active(pll_active),
    .pll_lock(pll_lock));
  vco_lock_model pll (.mclk(mclk), .cfg(pll_cfg), .vco(vco_ctl),
    .lock(lock_detect));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge mclk);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge mclk);
    cfg_rd = 1'b0;
    rv = cfg_rdata;
  endtask
  // Host band correction; clamp keeps clear of the auto code
  function automatic logic [5:0] fix(input logic [5:0] rb, input int tc);
    int n;
    n = rb;
    if (tc < -30 && rb > 6'd31) n = n + 3;
    else if (tc < -10) n = n + 2;
    else if (tc < 15) n = n + 1;
    else if (tc >= 55) n = n - 1;
    if (n < 0) n = 0;
    if (n > 62) n = 62;
    return n[5:0];
  endfunction
  task automatic finish_test;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    rd(VCO_BAND_ADDR);
    chk(rv, 8'h03);
    rd(8'h05);
    chk(rv, READ_ZERO);
    wr(PLL_DIV_ADDR, 8'hB3);
    rd(PLL_DIV_ADDR);
    chk(rv, 8'hB3);
    chk(pll_cfg, 8'hB3);
    chk({7'h00, pll_active}, 8'h01);
    wr(VCO_BAND_ADDR, 8'hFF);
    rd(VCO_BAND_ADDR);
    chk(rv, 8'hFF);
    chk({7'h00, pll_lock}, 8'h00);
    t = 0;
    while (pll_lock !== 1'b1 && t < 1000) begin
      @(negedge mclk);
      t++;
    end
    chk({7'h00, pll_lock}, 8'h01);
    rd(LOCK_STATUS_ADDR);
    chk(rv & 8'h02, 8'h02);
    rd(VCO_BAND_ADDR);
    chk(rv, 8'h17);
    foreach (rbs[j]) begin
      foreach (temps[i]) begin
        b = fix(rbs[j], temps[i]);
        wr(VCO_BAND_ADDR, {b, 2'h3});
        rd(VCO_BAND_ADDR);
        chk(rv, {b, 2'h3});
        chk(vco_ctl, {b, 2'h3});
      end
    end
    chk({7'h00, pll_lock}, 8'h00);
    wr(PLL_DIV_ADDR, 8'h33);
    @(negedge mclk);
    chk({7'h00, pll_active}, 8'h00);
    finish_test();
  end
  // Run needs some 125 cycles; allow about 80 times that
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule // test_pll_band_select
`default_nettype wire

// >>> dv/vco_lock_model.sv
// Behavioural analog PLL: raises lock when the band fits the VCO target.
// Assumes band and config come straight from the design outputs.
`timescale 1ns/1ps
`default_nettype none
module vco_lock_model
  import pll_band_pkg::*;
#(
  parameter logic [5:0] FIT_LO = 6'h05
) (
  // Design side
  input  wire logic                    mclk,
  input  wire pll_band_pkg::pll_cfg_t  cfg,
  input  wire pll_band_pkg::vco_band_t vco,
  output logic                         lock
);
  // Two bands fit, as the real bands overlap
  always_ff @(posedge mclk) begin
    lock <= cfg.pll_en && vco.band >= FIT_LO && vco.band <= FIT_LO + 6'h01;
  end
endmodule // vco_lock_model
`default_nettype wire

// >>> hw/pll_band_pkg.sv
// Constants and types for the PLL band select block.
// Assumes a 100 MHz mclk and register access through the config port.
package pll_band_pkg;
  // ------------------------------------------------------------
  // Register map and fields
  // ------------------------------------------------------------
  localparam logic [7:0] LOCK_STATUS_ADDR = 8'h00;
  localparam logic [7:0] VCO_BAND_ADDR    = 8'h08;
  localparam logic [7:0] PLL_DIV_ADDR     = 8'h09;
  localparam int         LOCK_BIT         = 1;
  localparam int         BAND_W           = 6;
  localparam logic [5:0] BAND_AUTO        = 6'h3F;
  localparam logic [5:0] BAND_MAX         = 6'h3E;
  localparam logic [5:0] BAND_MIN         = 6'h00;
  localparam logic [1:0] DRIVE_RST        = 2'h3;
  localparam logic [5:0] BAND_RST         = 6'h00;
  localparam logic [7:0] READ_ZERO        = 8'h00;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ         = 100;
  localparam int DWELL_US        = 20;
  localparam int DWELL_CYC       = DWELL_US * CLK_MHZ;
  localparam int LOCK_TIMEOUT_MS = 5;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       pll_en;
    logic [1:0] vco_divider;
    logic [1:0] sample_clock_multiplier;
    logic [2:0] bias;
  } pll_cfg_t;

  typedef struct packed {
    logic [5:0] band;
    logic [1:0] drive;
  } vco_band_t;

  typedef enum logic [1:0] {
    ST_FIXED,
    ST_SEARCH,
    ST_LOCKED
  } band_state_t;
endpackage

// >>> hw/pll_band_select.sv
// PLL VCO band select with automatic band search and lock reporting.
// Assumes decoded config-port strobes and an analog lock detector input.
`timescale 1ns/1ps
`default_nettype none
module pll_band_select
  import pll_band_pkg::*;
#(
  parameter int DWELL = pll_band_pkg::DWELL_CYC
) (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // Decoded config port
  input  wire logic [7:0]              cfg_addr,
  input  wire logic                    cfg_wr,
  input  wire logic [7:0]              cfg_wdata,
  input  wire logic                    cfg_rd,
  output logic      [7:0]              cfg_rdata,
  // Analog PLL side
  input  wire logic                    lock_detect,
  output pll_band_pkg::pll_cfg_t       pll_cfg,
  output pll_band_pkg::vco_band_t      vco_ctl,
  output logic                         pll_active,
  // Pins
  output logic                         pll_lock
);
  import pll_band_pkg::*;

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // The 13-bit dwell counter holds dwells of up to 8192 cycles; DWELL is limited to 4096
  if (DWELL < 1 || DWELL > 4096) begin : g_bad_dwell
    $error("DWELL out of range");
  end


  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  pll_cfg_t    cfg_r;
  vco_band_t   band_r;
  band_state_t state_r;
  logic [12:0] dwell_r;
  logic        lock_r;
  logic        band_wr;

  assign band_wr = cfg_wr && cfg_addr == VCO_BAND_ADDR;

  // ------------------------------------------------------------
  // Divider and enable register
  // ------------------------------------------------------------
  // Whole byte taken at once; host sets every field before auto
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_r <= '0;
    end else if (cfg_wr && cfg_addr == PLL_DIV_ADDR) begin
      cfg_r <= pll_cfg_t'(cfg_wdata);
    end
  end

  // ------------------------------------------------------------
  // Band search
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_FIXED;
      band_r  <= '{band: BAND_RST, drive: DRIVE_RST};
      dwell_r <= '0;
    end else if (band_wr) begin
      // A band write also aborts a running search
      band_r.drive <= cfg_wdata[1:0];
      dwell_r      <= '0;
      if (cfg_wdata[7:2] == BAND_AUTO) begin
        state_r     <= ST_SEARCH;
        band_r.band <= BAND_MIN;
      end else begin
        state_r     <= ST_FIXED;
        band_r.band <= cfg_wdata[7:2];
      end
    end else if (state_r == ST_SEARCH) begin
      // Each band gets a full dwell so the loop can settle
      if (dwell_r != 13'(DWELL - 1)) begin
        dwell_r <= dwell_r + 13'h0001;
      end else begin
        dwell_r <= '0;
        if (lock_detect) begin
          state_r <= ST_LOCKED;
        end else if (band_r.band != BAND_MAX) begin
          band_r.band <= band_r.band + 6'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Lock report
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      lock_r <= 1'b0;
    end else begin
      // Hidden while searching: lock on a passing band is not final
      lock_r <= cfg_r.pll_en && lock_detect && state_r != ST_SEARCH;
    end
  end

  assign pll_lock   = lock_r;
  assign pll_cfg    = cfg_r;
  assign vco_ctl    = band_r;
  assign pll_active = cfg_r.pll_en;

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_rdata <= READ_ZERO;
    end else if (cfg_rd) begin
      // A write in the same cycle shows only on the next read
      unique case (cfg_addr)
        LOCK_STATUS_ADDR: begin
          cfg_rdata         <= READ_ZERO;
          cfg_rdata[LOCK_BIT] <= lock_r;
        end
        VCO_BAND_ADDR: begin
          // Auto code reads back until the search settles
          cfg_rdata <= {(state_r == ST_SEARCH) ? BAND_AUTO : band_r.band,
                        band_r.drive};
        end
        PLL_DIV_ADDR: cfg_rdata <= cfg_r;
        default:      cfg_rdata <= READ_ZERO;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // All checks live in the mclk domain
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  band_in_range_a: assert property (
    band_r.band <= BAND_MAX) else $error("band code above 62");
  fixed_band_a: assert property (
    band_wr && cfg_wdata[7:2] != BAND_AUTO
    |=> band_r.band == $past(cfg_wdata[7:2]) && state_r == ST_FIXED)
    else $error("fixed band not applied");
  auto_start_a: assert property (
    band_wr && cfg_wdata[7:2] == BAND_AUTO
    |=> state_r == ST_SEARCH && band_r.band == BAND_MIN)
    else $error("auto mode not entered");
  search_lock_a: assert property (
    state_r == ST_SEARCH && !band_wr && dwell_r == 13'(DWELL - 1)
    && lock_detect |=> state_r == ST_LOCKED && $stable(band_r.band))
    else $error("search did not settle on locking band");
  search_step_a: assert property (
    state_r == ST_SEARCH && !band_wr && dwell_r != 13'(DWELL - 1)
    |=> $stable(band_r.band)) else $error("band moved inside dwell");
  lock_pin_a: assert property (
    cfg_r.pll_en && lock_detect && state_r == ST_LOCKED
    ##1 (cfg_r.pll_en && lock_detect && state_r == ST_LOCKED)
    |-> pll_lock) else $error("lock pin low while locked");
  no_lock_search_a: assert property (
    state_r == ST_SEARCH |=> !pll_lock)
    else $error("lock shown during search");
  band_readback_a: assert property (
    cfg_rd && cfg_addr == VCO_BAND_ADDR && state_r == ST_LOCKED
    |=> cfg_rdata[7:2] == $past(band_r.band))
    else $error("readback differs from chosen band");
  bypass_a: assert property (
    cfg_wr && cfg_addr == PLL_DIV_ADDR
    |=> pll_active == $past(cfg_wdata[7]))
    else $error("multiplier enable not applied");
  no_lock_bypass_a: assert property (
    !cfg_r.pll_en |=> !pll_lock)
    else $error("lock shown with multiplier off");
  lock_status_a: assert property (
    cfg_rd && cfg_addr == LOCK_STATUS_ADDR
    |=> cfg_rdata[LOCK_BIT] == $past(pll_lock))
    else $error("lock status bit differs from pin");
  search_read_a: assert property (
    cfg_rd && cfg_addr == VCO_BAND_ADDR && state_r == ST_SEARCH
    |=> cfg_rdata[7:2] == BAND_AUTO)
    else $error("auto code not shown during search");
  drive_field_a: assert property (
    band_wr |=> band_r.drive == $past(cfg_wdata[1:0]))
    else $error("drive field not stored");

  // ------------------------------------------------------------
  // Covers
  // ------------------------------------------------------------
  auto_locked_c: cover property (
    state_r == ST_SEARCH ##1 state_r == ST_LOCKED);
  fixed_after_auto_c: cover property (
    state_r == ST_LOCKED ##[1:20] state_r == ST_FIXED);
  lock_read_c: cover property (
    cfg_rd && cfg_addr == LOCK_STATUS_ADDR && lock_r);
  bypass_c: cover property (
    cfg_r.pll_en ##1 !cfg_r.pll_en);
  search_read_c: cover property (
    cfg_rd && cfg_addr == VCO_BAND_ADDR && state_r == ST_SEARCH);
endmodule // pll_band_select
`default_nettype wire
